// ===== design/cmp_ctrl_pkg.sv
// cmp_ctrl_pkg: register offset, field positions, reset values for the comparator control block
// assumes an ahb-lite slave with 32-bit data; the register is 16 bits in the low half of one word
package cmp_ctrl_pkg;
  // register map
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  // field positions inside comparator_control
  localparam int BIT_STOP_IDLE   = 15;
  localparam int BIT_EVT2        = 13;
  localparam int BIT_EVT1        = 12;
  localparam int BIT_EN2         = 11;
  localparam int BIT_EN1         = 10;
  localparam int BIT_PAD2        = 9;
  localparam int BIT_PAD1        = 8;
  localparam int BIT_RES2        = 7;
  localparam int BIT_RES1        = 6;
  localparam int BIT_INV2        = 5;
  localparam int BIT_INV1        = 4;
  localparam int BIT_NEG2        = 3;
  localparam int BIT_POS2        = 2;
  localparam int BIT_NEG1        = 1;
  localparam int BIT_POS1        = 0;
  // plain read/write bits: 15, 11..8, 5..0
  localparam logic [15:0] RW_MASK       = 16'h8f3f;
  // ahb htrans codes
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
  // reset synchroniser depth
  localparam int RST_SYNC_STAGES = 2;
  // bus state
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } bus_state_t;
endpackage

// ===== design/dual_comparator_control.sv
// dual_comparator_control: control/status logic around two analog comparators
// assumes raw comparator outputs arrive asynchronously and the mux/analog side honours the select bits
//
// Functional notes
// R01 - each comparator output change sets its sticky event flag until software clears it
// R02 - each comparator has an independent enable bit
// R03 - pad drive enable gates each comparator result onto its output pad
// R04 - result bit reads one when positive input exceeds negative, reversed by invert
// R05 - stop-in-idle with processor idle suppresses interrupts, comparators stay enabled
// R06 - each comparator has an invert control bit
// R07 - positive select picks external positive pin when set, internal reference when clear
// R08 - negative select picks external positive pin when set, external negative pin when clear
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control
  import cmp_ctrl_pkg::*;
(
  // clock, reset, enable
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic        CLK_EN,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // analog comparator side
  input  wire logic [1:0]  CMP_RAW,
  output logic      [1:0]  CMP_ENABLE,
  output logic      [1:0]  CMP_POS_SEL,
  output logic      [1:0]  CMP_NEG_SEL,
  // pad side
  output logic      [1:0]  PAD_OUT,
  output logic      [1:0]  PAD_OE,
  // processor idle and event strobes
  input  wire logic        CPU_IDLE,
  output logic      [1:0]  CMP_EVENT_REQ
);

  // reset release through two flops
  logic [RST_SYNC_STAGES-1:0] rst_sync_q;
  logic                       rst_n;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) rst_sync_q <= '0;
    else        rst_sync_q <= {rst_sync_q[RST_SYNC_STAGES-2:0], 1'b1};
  end
  assign rst_n = rst_sync_q[RST_SYNC_STAGES-1];

  // comparator inputs are asynchronous: two flops, only the second is read
  logic [1:0] raw_s1_q, raw_s2_q, raw_s1_d, raw_s2_d;
  always_comb begin
    raw_s1_d = CMP_RAW;
    raw_s2_d = raw_s1_q;
  end
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      raw_s1_q <= 2'h0;
      raw_s2_q <= 2'h0;
    end else if (CLK_EN) begin
      raw_s1_q <= raw_s1_d;
      raw_s2_q <= raw_s2_d;
    end
  end

  // register state
  logic [15:0] ctrl_q, ctrl_d;
  logic [1:0]  res_q, res_d;
  logic [1:0]  evt_q, evt_d;
  logic [1:0]  evt_req_q, evt_req_d;
  logic        idle_s1_q, idle_q;

  // bus address-phase capture
  bus_state_t  bus_q, bus_d;
  logic        wr_q, wr_d;
  logic        hit_q, hit_d;
  logic [31:0] rdata_q, rdata_d;

  logic [1:0] en, inv, change;
  logic       take, wr_go;
  assign en  = {ctrl_q[BIT_EN2], ctrl_q[BIT_EN1]};
  assign inv = {ctrl_q[BIT_INV2], ctrl_q[BIT_INV1]};

  // result follows raw input xor invert; disabled comparators read zero
  always_comb begin
    res_d  = (raw_s2_q ^ inv) & en; // R04 R06 R02
    change = res_d ^ res_q;         // R01
  end

  // ahb decode: single-cycle data phase, always OKAY, unmapped reads zero
  assign take  = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);
  assign wr_go = (bus_q == BUS_DATA) && wr_q && hit_q;
  always_comb begin
    bus_d   = take ? BUS_DATA : BUS_IDLE;
    wr_d    = take && HWRITE;
    hit_d   = take && (HADDR[7:0] == CTRL_OFFSET) && (HADDR[31:8] == 24'h000000);
    rdata_d = 32'h0000_0000;
    // next-state values are read, so a read pipelined behind a write sees that write
    if (take && !HWRITE && hit_d) begin
      rdata_d = {16'h0000, ctrl_d[15:14], evt_d, ctrl_d[11:8], res_q, ctrl_d[5:0]};
    end
  end

  // control bits and sticky event flags; writing zero to a flag clears it, a new change wins
  always_comb begin
    ctrl_d = ctrl_q;
    evt_d  = evt_q;
    if (wr_go) begin
      ctrl_d = HWDATA[15:0] & RW_MASK; // R02 R03 R06 R07 R08
      evt_d  = evt_q & {HWDATA[BIT_EVT2], HWDATA[BIT_EVT1]};
    end
    evt_d = evt_d | change; // R01
  end

  // event request pulses, held off in idle when stop-in-idle is set
  always_comb begin
    evt_req_d = change;
    if (ctrl_q[BIT_STOP_IDLE] && idle_q) begin
      evt_req_d = 2'h0; // R05
    end
  end

  // registers
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q    <= CTRL_RESET;
      res_q     <= 2'h0;
      evt_q     <= 2'h0;
      evt_req_q <= 2'h0;
      idle_s1_q <= 1'b0;
      idle_q    <= 1'b0;
      bus_q     <= BUS_IDLE;
      wr_q      <= 1'b0;
      hit_q     <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end else if (CLK_EN) begin
      ctrl_q    <= ctrl_d;
      res_q     <= res_d;
      evt_q     <= evt_d;
      evt_req_q <= evt_req_d;
      idle_s1_q <= CPU_IDLE;
      idle_q    <= idle_s1_q;
      bus_q     <= bus_d;
      wr_q      <= wr_d;
      hit_q     <= hit_d;
      rdata_q   <= rdata_d;
    end
  end

  // outputs; stop-in-idle leaves comparators enabled
  assign HRDATA        = rdata_q;
  assign HREADYOUT     = 1'b1;
  assign HRESP         = 1'b0;
  assign CMP_ENABLE    = en;                                          // R02 R05
  assign CMP_POS_SEL   = {ctrl_q[BIT_POS2], ctrl_q[BIT_POS1]};        // R07
  assign CMP_NEG_SEL   = {ctrl_q[BIT_NEG2], ctrl_q[BIT_NEG1]};        // R08
  assign PAD_OE        = {ctrl_q[BIT_PAD2], ctrl_q[BIT_PAD1]} & en;   // R03
  assign PAD_OUT       = res_q & PAD_OE;                              // R03
  assign CMP_EVENT_REQ = evt_req_q;

  // assertions: each ties an output or an internal flag or control bit to the bus write, pin level or control setting that governs it
  property p_evt_set;
    @(posedge CLOCK) disable iff (!rst_n) CLK_EN && (res_d != res_q) |=> (evt_q & $past(change)) == $past(change);
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("event flag not set on change"); // R01
  property p_evt_sticky;
    @(posedge CLOCK) disable iff (!rst_n) CLK_EN && !wr_go && (change == 2'h0) |=> evt_q == $past(evt_q);
  endproperty
  a_evt_sticky: assert property (p_evt_sticky) else $error("event flag changed without cause"); // R01
  property p_evt_clear;
    @(posedge CLOCK) disable iff (!rst_n) CLK_EN && wr_go && (change == 2'h0) |=>
      (evt_q & ~{$past(HWDATA[BIT_EVT2]), $past(HWDATA[BIT_EVT1])}) == 2'h0;
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("event flag not cleared by zero"); // R01
  property p_enable;
    @(posedge CLOCK) disable iff (!rst_n) CLK_EN && wr_go |=>
      CMP_ENABLE == {$past(HWDATA[BIT_EN2]), $past(HWDATA[BIT_EN1])};
  endproperty
  a_enable: assert property (p_enable) else $error("enable bits not written"); // R02
  property p_pad;
    @(posedge CLOCK) disable iff (!rst_n) CLK_EN && wr_go |=>
      PAD_OE == ({$past(HWDATA[BIT_PAD2]), $past(HWDATA[BIT_PAD1])} &
                 {$past(HWDATA[BIT_EN2]), $past(HWDATA[BIT_EN1])});
  endproperty
  a_pad: assert property (p_pad) else $error("pad drive wrong"); // R03
  property p_pad_quiet;
    @(posedge CLOCK) disable iff (!rst_n) (PAD_OUT & ~PAD_OE) == 2'h0;
  endproperty
  a_pad_quiet: assert property (p_pad_quiet) else $error("pad driven while drive is off"); // R03
  // the raw pin reaches the result three edges later, both sync flops loaded out of reset
  property p_result;
    @(posedge CLOCK) disable iff (!rst_n)
      CLK_EN && $past(CLK_EN) && $past(CLK_EN, 2) && $past(rst_n) && $past(rst_n, 2)
      |=> res_q == (($past(CMP_RAW, 3) ^ $past(inv)) & $past(en));
  endproperty
  a_result: assert property (p_result) else $error("result bit wrong"); // R04
  property p_idle;
    @(posedge CLOCK) disable iff (!rst_n) CLK_EN && ctrl_q[BIT_STOP_IDLE] && idle_q |=> CMP_EVENT_REQ == 2'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("event request in idle"); // R05
  property p_idle_enabled;
    @(posedge CLOCK) disable iff (!rst_n) CLK_EN && ctrl_q[BIT_STOP_IDLE] && idle_q && !wr_go |=>
      CMP_ENABLE == $past(CMP_ENABLE);
  endproperty
  a_idle_enabled: assert property (p_idle_enabled) else $error("comparator disabled by idle"); // R05
  property p_awake;
    @(posedge CLOCK) disable iff (!rst_n) CLK_EN && !(ctrl_q[BIT_STOP_IDLE] && idle_q) |=>
      CMP_EVENT_REQ == $past(change);
  endproperty
  a_awake: assert property (p_awake) else $error("event request missing"); // R05
  property p_invert;
    @(posedge CLOCK) disable iff (!rst_n) CLK_EN && wr_go |=>
      inv == {$past(HWDATA[BIT_INV2]), $past(HWDATA[BIT_INV1])};
  endproperty
  a_invert: assert property (p_invert) else $error("invert bits not written"); // R06
  property p_pos;
    @(posedge CLOCK) disable iff (!rst_n) CLK_EN && wr_go |=>
      CMP_POS_SEL == {$past(HWDATA[BIT_POS2]), $past(HWDATA[BIT_POS1])};
  endproperty
  a_pos: assert property (p_pos) else $error("positive select wrong"); // R07
  property p_neg;
    @(posedge CLOCK) disable iff (!rst_n) CLK_EN && wr_go |=>
      CMP_NEG_SEL == {$past(HWDATA[BIT_NEG2]), $past(HWDATA[BIT_NEG1])};
  endproperty
  a_neg: assert property (p_neg) else $error("negative select wrong"); // R08
  c_write: cover property (@(posedge CLOCK) disable iff (!rst_n) wr_go);
  c_clear: cover property (@(posedge CLOCK) disable iff (!rst_n) wr_go && (evt_q != 2'h0));
  c_evt: cover property (@(posedge CLOCK) disable iff (!rst_n) change != 2'h0);
  c_idle: cover property (@(posedge CLOCK) disable iff (!rst_n) ctrl_q[BIT_STOP_IDLE] && idle_q && change != 2'h0);
endmodule
`default_nettype wire

// ===== dv/cmp_analog_model.sv
// cmp_analog_model: the two analog comparators and their input muxes
// assumes the bench sets the three pin levels as plain 8-bit numbers
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model (
  // controls from the block
  input  wire logic [1:0] enable,
  input  wire logic [1:0] pos_sel,
  input  wire logic [1:0] neg_sel,
  // analog levels, shared by both comparators
  input  wire logic [7:0] v_pos,
  input  wire logic [7:0] v_neg,
  input  wire logic [7:0] v_ref,
  // raw comparator outputs
  output logic      [1:0] raw
);
  // mux each input, then compare; a powered-down comparator rests low
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      raw[i] = enable[i] & ((pos_sel[i] ? v_pos : v_ref) >
                            (neg_sel[i] ? v_pos : v_neg));
    end
  end
endmodule
`default_nettype wire

// ===== dv/test_dual_comparator_control.sv
// test_dual_comparator_control: register-level tests of the comparator control block
// assumes a zero-wait ahb-lite slave and the analog model at its far side
`timescale 1ns/1ps
`default_nettype none
module test_dual_comparator_control;
  import cmp_ctrl_pkg::*;
  logic        CLOCK = 1'b0, RST_B = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, CPU_IDLE = 1'b0, e;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
  logic [1:0]  HTRANS = 2'h0, CMP_RAW, CMP_ENABLE, CMP_POS_SEL, CMP_NEG_SEL, PAD_OUT, PAD_OE, CMP_EVENT_REQ;
  logic        HREADYOUT, HRESP;
  logic [7:0]  v_pos = 8'h64, v_neg = 8'h32, v_ref = 8'h14;
  logic [15:0] ctl;
  int          errors = 0, checked = 0, pulses = 0, base = 0;
  always #4 CLOCK = ~CLOCK;
  // both comparators pulse in one cycle, so a cycle counts once
  always @(posedge CLOCK) if (CMP_EVENT_REQ !== 2'h0) pulses <= pulses + 1;
  dual_comparator_control dut (.CLOCK, .RST_B, .CLK_EN(1'b1), .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2),
    .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .CMP_RAW, .CMP_ENABLE, .CMP_POS_SEL,
    .CMP_NEG_SEL, .PAD_OUT, .PAD_OE, .CPU_IDLE, .CMP_EVENT_REQ);
  cmp_analog_model far (.enable(CMP_ENABLE), .pos_sel(CMP_POS_SEL), .neg_sel(CMP_NEG_SEL), .v_pos, .v_neg,
    .v_ref, .raw(CMP_RAW));
  task automatic end_of_test();
    $display("counts: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge CLOCK);
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 40);
    if (HREADYOUT !== 1'b1) begin
      errors++;
      end_of_test();
    end
  endtask
  // one single word transfer; read data lands in rd
  task automatic bus(logic w, logic [31:0] a, logic [15:0] d);
    HSEL   <= 1'b1;
    HADDR  <= a;
    HWRITE <= w;
    HTRANS <= HTRANS_NONSEQ;
    wait_rdy();
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= {16'h0, d};
    wait_rdy();
    rd = HRDATA;
    chk("response", 32'h0, {31'h0, HRESP});
  endtask
  initial begin
    cyc(20);
    RST_B <= 1'b1;
    cyc(4);
    bus(1'b0, 32'h0, 16'h0);
    chk("reset value", 32'h0, rd);
    // every select and invert setting, mirrored on both comparators
    for (int k = 0; k < 8; k++) begin
      ctl = {8'h0c, 2'h0, {2{k[2]}}, k[1], k[0], k[1], k[0]};
      e = ((k[0] ? v_pos : v_ref) > (k[1] ? v_pos : v_neg)) ^ k[2];
      bus(1'b1, 32'h0, ctl);
      cyc(6);
      bus(1'b0, 32'h0, 16'h0);
      chk("result", {16'h0, ctl | {8'h0, e, e, 6'h0}}, rd & 32'hcfff);
      chk("pos select", {2{k[0]}}, CMP_POS_SEL);
      chk("neg select", {2{k[1]}}, CMP_NEG_SEL);
    end
    bus(1'b1, 32'h0, 16'h0405);
    cyc(6);
    bus(1'b0, 32'h0, 16'h0);
    chk("one enabled", 32'h0445, rd & 32'hcfff);
    chk("enable", 32'h1, CMP_ENABLE);
    $display("test selects done");
    bus(1'b1, 32'h0, 16'h0c05);
    cyc(6);
    bus(1'b1, 32'h0, 16'h0c05); // clear flags raised by the set-up
    bus(1'b0, 32'h0, 16'h0);
    chk("flags clear", 32'h0cc5, rd);
    v_pos <= 8'h0a;
    cyc(8);
    bus(1'b1, 32'h0, 16'h3c05); // ones must leave the flags alone
    bus(1'b0, 32'h0, 16'h0);
    chk("flags set", 32'h3c05, rd);
    bus(1'b1, 32'h0, 16'h0c05);
    bus(1'b0, 32'h0, 16'h0);
    chk("flags cleared", 32'h0c05, rd);
    $display("test events done");
    v_pos <= 8'h64;
    bus(1'b1, 32'h0, 16'h0f05);
    cyc(6);
    chk("pad drive", 32'hf, {PAD_OE, PAD_OUT});
    bus(1'b1, 32'h0, 16'h0f35);
    cyc(6);
    chk("pad inverted", 32'hc, {PAD_OE, PAD_OUT});
    bus(1'b1, 32'h0, 16'h0c05);
    cyc(6);
    chk("pad off", 32'h0, {PAD_OE, PAD_OUT});
    $display("test pads done");
    bus(1'b1, 32'h0, 16'h8c05);
    CPU_IDLE <= 1'b1;
    cyc(6);
    base = pulses;
    v_pos <= 8'h0a;
    cyc(10);
    chk("idle requests", 32'h0, pulses - base);
    chk("enabled in idle", 32'h3, CMP_ENABLE);
    CPU_IDLE <= 1'b0;
    cyc(6);
    base = pulses;
    v_pos <= 8'h64;
    cyc(10);
    chk("awake requests", 32'h1, pulses - base);
    bus(1'b1, 32'h4, 16'hffff);
    bus(1'b0, 32'h4, 16'h0);
    chk("unmapped read", 32'h0, rd);
    bus(1'b0, 32'h0, 16'h0);
    chk("unmapped write", 32'h8cc5, rd & 32'hcfff);
    // stop-in-idle clear: idle must not hold requests back
    bus(1'b1, 32'h0, 16'h0c05);
    CPU_IDLE <= 1'b1;
    cyc(6);
    base = pulses;
    v_pos <= 8'h0a;
    cyc(10);
    chk("idle normal requests", 32'h1, pulses - base);
    $display("test idle and map done");
    end_of_test();
  end
endmodule
`default_nettype wire
